// file: hdl/ascfg_top.sv
// strap decode, configuration load and operating mode selection
// straps are static board wiring sampled through synchronisers; the register
// port is synchronous to REF_CLK; negotiation engine lives outside this block
`timescale 1ns/100ps
module ascfg_top
    import ascfg_pkg::*;
(
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RESETN,
    // strap comparator outputs, a is the high threshold, b the mid threshold
    input wire logic STRAP_SEL_FIRST_A,
    input wire logic STRAP_SEL_FIRST_B,
    input wire logic STRAP_SEL_SECOND_A,
    input wire logic STRAP_SEL_SECOND_B,
    // management register port
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [ADDR_W-1:0] REG_ADDR,
    input wire logic [DATA_W-1:0] REG_WDATA,
    output logic [DATA_W-1:0] REG_RDATA,
    // negotiation engine side
    input wire logic AN_COMPLETE,
    input wire logic LINK_UP,
    input wire logic PARTNER_LOAD,
    input wire logic [DATA_W-1:0] PARTNER_WORD,
    output logic [DATA_W-1:0] ADVERT_WORD,
    output logic AN_ENABLE,
    // resolved operating mode
    output logic MODE_100,
    output logic MODE_FULL,
    output logic MODE_VALID,
    output logic CFG_DONE
);
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic filled_q;
    ascfg_state_t state_q;
    ascfg_level_t lvl_first;
    ascfg_level_t lvl_second;
    logic [ADV_LO_W-1:0] strap_adv;
    logic strap_an;
    logic [DATA_W-1:0] control_q;
    logic [DATA_W-1:0] advert_q;
    logic [DATA_W-1:0] partner_q;
    logic strap_an_q;
    logic [DATA_W-1:0] common;
    logic res_100;
    logic res_full;
    logic res_any;
    logic [DATA_W-1:0] status;

    // two-stage synchroniser on comparator outputs
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
        end else begin
            sync1_q <= {STRAP_SEL_FIRST_A, STRAP_SEL_FIRST_B,
                        STRAP_SEL_SECOND_A, STRAP_SEL_SECOND_B};
            sync2_q <= sync1_q;
        end
    end

    function automatic ascfg_level_t decode(input logic a, input logic b);
        if (a && b) begin
            decode = ASCFG_HIGH; // RULE_01
        end else if (b) begin
            decode = ASCFG_MID; // RULE_01
        end else begin
            decode = ASCFG_LOW; // RULE_01
        end
    endfunction : decode

    assign lvl_first = decode(sync2_q[3], sync2_q[2]);
    assign lvl_second = decode(sync2_q[1], sync2_q[0]);

    // strap table
    always_comb begin
        strap_an = 1'b1;
        strap_adv = ADV_ALL; // RULE_03
        unique case ({lvl_first, lvl_second})
            {ASCFG_LOW, ASCFG_MID}: begin
                strap_an = 1'b0;
                strap_adv = ADV_F10H; // RULE_05
            end
            {ASCFG_HIGH, ASCFG_MID}: begin
                strap_an = 1'b0;
                strap_adv = ADV_F10F; // RULE_06
            end
            {ASCFG_MID, ASCFG_LOW}: begin
                strap_an = 1'b0;
                strap_adv = ADV_F100H; // RULE_07
            end
            {ASCFG_MID, ASCFG_HIGH}: begin
                strap_an = 1'b0;
                strap_adv = ADV_F100F; // RULE_08
            end
            {ASCFG_MID, ASCFG_MID}: strap_adv = ADV_ALL; // RULE_09
            {ASCFG_LOW, ASCFG_LOW}: strap_adv = ADV_10; // RULE_10
            {ASCFG_LOW, ASCFG_HIGH}: strap_adv = ADV_100; // RULE_11
            {ASCFG_HIGH, ASCFG_LOW}: strap_adv = ADV_HALF; // RULE_12
            {ASCFG_HIGH, ASCFG_HIGH}: strap_adv = ADV_10H_ONLY; // RULE_13
            default: strap_adv = ADV_ALL;
        endcase
    end

    // second stage holds real strap samples from the second edge after release
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            filled_q <= 1'b0;
        end else begin
            filled_q <= 1'b1;
        end
    end

    // load sequence: wait for synchroniser to fill, then load once
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_q <= ASCFG_IDLE;
        end else begin
            unique case (state_q)
                ASCFG_IDLE: state_q <= filled_q ? ASCFG_LOAD : ASCFG_IDLE;
                ASCFG_LOAD: state_q <= ASCFG_RUN;
                ASCFG_RUN: state_q <= ASCFG_RUN; // RULE_21
            endcase
        end
    end

    // strap-driven status bit, captured once
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            strap_an_q <= 1'b1;
        end else if (state_q == ASCFG_LOAD) begin
            strap_an_q <= strap_an; // RULE_02 RULE_04 RULE_21
        end
    end

    // control register, untouched by straps
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            control_q <= CONTROL_RST; // RULE_16
        end else if (REG_WR && REG_ADDR == OFS_CONTROL) begin
            control_q <= REG_WDATA; // RULE_15
        end
    end

    // advertisement register: strap load, then software owns it
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            advert_q <= {{(DATA_W-ADV_LO_W){1'b0}}, ADV_ALL}; // RULE_03
        end else if (REG_WR && REG_ADDR == OFS_ADVERT) begin
            advert_q <= REG_WDATA;
        end else if (state_q == ASCFG_LOAD) begin
            advert_q <= {advert_q[DATA_W-1:ADV_LO_W], strap_adv}; // RULE_02
        end
    end

    // partner abilities from the negotiation engine
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            partner_q <= 16'h0000;
        end else if (PARTNER_LOAD) begin
            partner_q <= PARTNER_WORD;
        end
    end

    // highest common ability
    assign common = advert_q & partner_q; // RULE_18
    always_comb begin
        res_any = 1'b1;
        res_100 = 1'b0;
        res_full = 1'b0;
        if (common[ADV_100F_BIT]) begin
            res_100 = 1'b1; // RULE_19
            res_full = 1'b1;
        end else if (common[ADV_100H_BIT]) begin
            res_100 = 1'b1; // RULE_19
        end else if (common[ADV_10F_BIT]) begin
            res_full = 1'b1; // RULE_19
        end else if (!common[ADV_10H_BIT]) begin
            res_any = 1'b0;
        end
    end

    // operating mode outputs
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            MODE_100 <= 1'b0;
            MODE_FULL <= 1'b0;
            MODE_VALID <= 1'b0;
        end else if (!control_q[CTL_AN_EN_BIT]) begin
            MODE_100 <= control_q[CTL_SPEED_BIT]; // RULE_20
            MODE_FULL <= control_q[CTL_DUPLEX_BIT]; // RULE_20
            MODE_VALID <= 1'b1;
        end else begin
            MODE_100 <= res_100; // RULE_18
            MODE_FULL <= res_full;
            MODE_VALID <= AN_COMPLETE && res_any;
        end
    end

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            ADVERT_WORD <= 16'h0000;
            AN_ENABLE <= 1'b0;
            CFG_DONE <= 1'b0;
        end else begin
            ADVERT_WORD <= advert_q; // RULE_14
            AN_ENABLE <= control_q[CTL_AN_EN_BIT] && (state_q == ASCFG_RUN);
            CFG_DONE <= state_q == ASCFG_RUN;
        end
    end

    // status word; bits 1 and 2 meaningful only once mode is valid
    always_comb begin
        status = 16'h0000;
        status[STS_STRAP_AN_BIT] = strap_an_q; // RULE_04
        status[STS_DUPLEX_BIT] = MODE_FULL; // RULE_17
        status[STS_SPEED10_BIT] = !MODE_100; // RULE_17
        status[STS_LINK_BIT] = LINK_UP;
    end

    // read data
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            REG_RDATA <= 16'h0000;
        end else if (REG_RD) begin
            unique case (REG_ADDR)
                OFS_CONTROL: REG_RDATA <= control_q;
                OFS_ADVERT: REG_RDATA <= advert_q;
                OFS_PARTNER: REG_RDATA <= partner_q;
                OFS_STATUS: REG_RDATA <= status;
                default: REG_RDATA <= 16'h0000;
            endcase
        end
    end
endmodule : ascfg_top

// file: hdl/ascfg_pkg.sv
// constants and types of the strap-driven auto-negotiation configuration block
// assumes a single 10 MHz device clock and a word-wide management register port
//
// Functional notes
// RULE_01: each strap is low, mid or high from two comparator outputs.
// RULE_02: reset loads advertisement bits 8:5 and status bit 9 from both straps.
// RULE_03: default straps give negotiation on, all four abilities advertised.
// RULE_04: status bit 9 is one for advertised modes, zero for forced modes.
// RULE_05: first low, second mid: forced 10 half, advertisement 0x021.
// RULE_06: first high, second mid: forced 10 full, advertisement 0x041.
// RULE_07: first mid, second low: forced 100 half, advertisement 0x081.
// RULE_08: first mid, second high: forced 100 full, advertisement 0x101.
// RULE_09: both mid: negotiate all four abilities, advertisement 0x1e1.
// RULE_10: both low: negotiate 10 half and full, advertisement 0x061.
// RULE_11: first low, second high: negotiate 100 half and full, 0x181.
// RULE_12: first high, second low: negotiate half duplex both speeds, 0x0a1.
// RULE_13: both high: negotiate 10 half only, advertisement 0x021.
// RULE_14: negotiation sends the current advertisement register contents.
// RULE_15: straps leave the control register alone; software writes it any time.
// RULE_16: control register never reflects strap-selected mode.
// RULE_17: software trusts status bits 1 and 2 only when valid.
// RULE_18: negotiated mode is the best ability common to both sides.
// RULE_19: priority 100 full, 100 half, 10 full, 10 half.
// RULE_20: negotiation off: speed from control bit 13, duplex from bit 8.
// RULE_21: strap levels captured once at reset release and then held.
package ascfg_pkg;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_ADVERT = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_PARTNER = 5'h05;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h10;
    // control bits
    localparam int CTL_SPEED_BIT = 13;
    localparam int CTL_AN_EN_BIT = 12;
    localparam int CTL_DUPLEX_BIT = 8;
    localparam logic [DATA_W-1:0] CONTROL_RST = 16'h3100;
    // status bits
    localparam int STS_STRAP_AN_BIT = 9;
    localparam int STS_DUPLEX_BIT = 2;
    localparam int STS_SPEED10_BIT = 1;
    localparam int STS_LINK_BIT = 0;
    // advertisement ability bits
    localparam int ADV_10H_BIT = 5;
    localparam int ADV_10F_BIT = 6;
    localparam int ADV_100H_BIT = 7;
    localparam int ADV_100F_BIT = 8;
    localparam int ADV_LO_W = 9;
    localparam logic [ADV_LO_W-1:0] ADV_F10H = 9'h021;
    localparam logic [ADV_LO_W-1:0] ADV_F10F = 9'h041;
    localparam logic [ADV_LO_W-1:0] ADV_F100H = 9'h081;
    localparam logic [ADV_LO_W-1:0] ADV_F100F = 9'h101;
    localparam logic [ADV_LO_W-1:0] ADV_ALL = 9'h1e1;
    localparam logic [ADV_LO_W-1:0] ADV_10 = 9'h061;
    localparam logic [ADV_LO_W-1:0] ADV_100 = 9'h181;
    localparam logic [ADV_LO_W-1:0] ADV_HALF = 9'h0a1;
    localparam logic [ADV_LO_W-1:0] ADV_10H_ONLY = 9'h021;
    typedef enum logic [1:0] {ASCFG_LOW, ASCFG_MID, ASCFG_HIGH} ascfg_level_t;
    typedef enum logic [1:0] {ASCFG_IDLE, ASCFG_LOAD, ASCFG_RUN} ascfg_state_t;
endpackage : ascfg_pkg

// file: tb/ascfg_strap_wiring.sv
// board strap wiring model: a three-level pin seen through two comparators
// the bench picks a level per strap; levels stay put around reset
`timescale 1ns/100ps
module ascfg_strap_wiring
    import ascfg_pkg::*;
(
    // chosen levels
    input wire logic [1:0] lvl_first,
    input wire logic [1:0] lvl_second,
    // comparator outputs
    output logic first_a,
    output logic first_b,
    output logic second_a,
    output logic second_b
);
    assign first_a = lvl_first == ASCFG_HIGH;
    assign first_b = lvl_first != ASCFG_LOW;
    assign second_a = lvl_second == ASCFG_HIGH;
    assign second_b = lvl_second != ASCFG_LOW;
endmodule : ascfg_strap_wiring

// file: tb/ascfg_top_sva.sv
// port assertions for the strap configuration block
// bound to ascfg_top from the bench top file
`timescale 1ns/100ps
module ascfg_top_sva
    import ascfg_pkg::*;
(
    input wire logic REF_CLK, RESETN, REG_WR, REG_RD, LINK_UP,
    input wire logic [ADDR_W-1:0] REG_ADDR,
    input wire logic [DATA_W-1:0] REG_WDATA, REG_RDATA, ADVERT_WORD,
    input wire logic AN_ENABLE, MODE_100, MODE_FULL, CFG_DONE
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);
    wire wr_ctl = REG_WR && REG_ADDR == OFS_CONTROL;
    wire wr_adv = REG_WR && REG_ADDR == OFS_ADVERT;
    property p_done_hold; CFG_DONE |=> CFG_DONE; endproperty
    a_done_hold: assert property (p_done_hold)
        else $error("config done dropped");
    property p_load_time; $rose(RESETN) |-> ##[0:4] CFG_DONE; endproperty
    a_load_time: assert property (p_load_time)
        else $error("strap load late");
    property p_forced;
        CFG_DONE && wr_ctl && !REG_WDATA[12] ##1 !wr_ctl |=>
            MODE_100 == $past(REG_WDATA[13], 2) && MODE_FULL == $past(REG_WDATA[8], 2);
    endproperty
    a_forced: assert property (p_forced)
        else $error("forced mode wrong");
    property p_an_en; CFG_DONE && wr_ctl ##1 !wr_ctl |=> AN_ENABLE == $past(REG_WDATA[12], 2);
    endproperty
    a_an_en: assert property (p_an_en)
        else $error("enable not following control");
    property p_adv_wr; CFG_DONE && wr_adv ##1 !wr_adv |=> ADVERT_WORD == $past(REG_WDATA, 2);
    endproperty
    a_adv_wr: assert property (p_adv_wr)
        else $error("advert word stale");
    property p_adv_rd;
        CFG_DONE && REG_RD && REG_ADDR == OFS_ADVERT && !REG_WR && !$past(REG_WR)
            && !$past(REG_WR, 2) |=> REG_RDATA == $past(ADVERT_WORD);
    endproperty
    a_adv_rd: assert property (p_adv_rd)
        else $error("advert read differs");
    property p_adv_keep;
        CFG_DONE && $past(CFG_DONE) && !$past(REG_WR) && !$past(REG_WR, 2) |-> $stable(ADVERT_WORD);
    endproperty
    a_adv_keep: assert property (p_adv_keep)
        else $error("advert moved without write");
    property p_sts;
        REG_RD && REG_ADDR == OFS_STATUS && $stable(LINK_UP) && $stable(MODE_FULL)
            && $stable(MODE_100) |=> REG_RDATA[2:0] == {$past(MODE_FULL), !$past(MODE_100),
            $past(LINK_UP)};
    endproperty
    a_sts: assert property (p_sts)
        else $error("status bits wrong");
    c_forced: cover property (wr_ctl && !REG_WDATA[12]);
    c_an: cover property (AN_ENABLE && MODE_100);
    c_sts: cover property (REG_RD && REG_ADDR == OFS_STATUS);
endmodule : ascfg_top_sva

// file: tb/test_autoneg_strap_config.sv
// self-checking bench: strap table, forced modes, resolution, hold
// uses the strap wiring model and the bound port checker
`timescale 1ns/100ps
module test_autoneg_strap_config
    import ascfg_pkg::*;
;
    logic REF_CLK, RESETN, REG_WR, REG_RD, AN_COMPLETE, LINK_UP, PARTNER_LOAD;
    logic STRAP_SEL_FIRST_A, STRAP_SEL_FIRST_B, STRAP_SEL_SECOND_A, STRAP_SEL_SECOND_B;
    logic [ADDR_W-1:0] REG_ADDR;
    logic [DATA_W-1:0] REG_WDATA, PARTNER_WORD, REG_RDATA, ADVERT_WORD, v, adv, part;
    logic AN_ENABLE, MODE_100, MODE_FULL, MODE_VALID, CFG_DONE;
    logic [1:0] lf, ls, k;
    int failures, tests_run, cycles, i, n, b, seed = 13249;
    int exp_adv[9] = '{'h061, 'h021, 'h181, 'h081, 'h1e1, 'h101, 'h0a1, 'h041, 'h021};
    int prio[$] = '{8, 7, 6, 5};
    ascfg_top dut (.REF_CLK, .RESETN, .STRAP_SEL_FIRST_A, .STRAP_SEL_FIRST_B,
        .STRAP_SEL_SECOND_A, .STRAP_SEL_SECOND_B, .REG_WR, .REG_RD, .REG_ADDR, .REG_WDATA,
        .REG_RDATA, .AN_COMPLETE, .LINK_UP, .PARTNER_LOAD, .PARTNER_WORD, .ADVERT_WORD,
        .AN_ENABLE, .MODE_100, .MODE_FULL, .MODE_VALID, .CFG_DONE);
    ascfg_strap_wiring straps (.lvl_first(lf), .lvl_second(ls), .first_a(STRAP_SEL_FIRST_A),
        .first_b(STRAP_SEL_FIRST_B), .second_a(STRAP_SEL_SECOND_A),
        .second_b(STRAP_SEL_SECOND_B));
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    task automatic tick();
        @(posedge REF_CLK) #1;
    endtask : tick
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        REG_WR = 1;
        REG_ADDR = a;
        REG_WDATA = d;
        tick();
        REG_WR = 0;
        tick();
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a);
        REG_RD = 1;
        REG_ADDR = a;
        tick();
        REG_RD = 0;
        tick();
        v = REG_RDATA;
    endtask : rd
    task automatic reset_dut();
        RESETN = 0;
        repeat (4) tick();
        RESETN = 1;
        for (n = 0; n < 20 && CFG_DONE !== 1'b1; n++) tick();
        chk(16'(CFG_DONE), 16'h1);
    endtask : reset_dut
    initial begin
        REF_CLK = 0;
        forever #50 REF_CLK = ~REF_CLK;
    end
    always @(posedge REF_CLK) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            print_verdict();
        end
    end
    initial begin
        {RESETN, REG_WR, REG_RD, AN_COMPLETE, LINK_UP, PARTNER_LOAD} = '0;
        {REG_ADDR, REG_WDATA, PARTNER_WORD} = '0;
        lf = ASCFG_MID;
        ls = ASCFG_MID;
        for (i = 0; i < 9; i++) begin
            lf = 2'(i / 3);
            ls = 2'(i % 3);
            reset_dut();
            rd(OFS_ADVERT);
            chk(v, 16'(exp_adv[i]));
            rd(OFS_STATUS);
            chk(v & 16'h0200, (lf == ASCFG_MID) == (ls == ASCFG_MID) ? 16'h0200 : 16'h0);
            rd(OFS_CONTROL);
            chk(v, CONTROL_RST);
            chk(16'(AN_ENABLE), 16'h1);
            lf = 2'($unsigned($random(seed)) % 3);
            ls = 2'($unsigned($random(seed)) % 3);
            repeat (4) tick();
            rd(OFS_ADVERT);
            chk(v, 16'(exp_adv[i]));
        end
        rd(5'h1f);
        chk(v, 16'h0);
        $display("test straps done");
        for (i = 0; i < 4; i++) begin
            k = 2'(i);
            LINK_UP = 1'($random(seed));
            wr(OFS_CONTROL, {2'b0, k[1], 4'b0, k[0], 8'h0});
            tick();
            chk({MODE_100, MODE_FULL}, {k[1], k[0]});
            rd(OFS_STATUS);
            chk(v & 16'h7, {k[0], ~k[1], LINK_UP});
            chk(16'(MODE_VALID), 16'h1);
        end
        $display("test forced modes done");
        AN_COMPLETE = 1;
        for (i = 0; i < 12; i++) begin
            adv = {7'h0, 4'($random(seed)), 5'h01};
            part = {7'h0, 4'($random(seed)), 5'h01};
            PARTNER_WORD = part;
            PARTNER_LOAD = 1;
            tick();
            PARTNER_LOAD = 0;
            wr(OFS_ADVERT, adv);
            wr(OFS_CONTROL, 16'h1000);
            repeat (3) tick();
            chk(ADVERT_WORD, adv);
            chk(16'(AN_ENABLE), 16'h1);
            foreach (prio[j]) begin
                b = prio[j];
                if (adv[b] && part[b]) break;
                b = 0;
            end
            if (b != 0) chk({MODE_100, MODE_FULL}, {b >= 7, b == 8 || b == 6});
            chk(16'(MODE_VALID), 16'(b != 0));
        end
        $display("test resolution done");
        print_verdict();
    end
endmodule : test_autoneg_strap_config
bind ascfg_top ascfg_top_sva u_sva (.REF_CLK, .RESETN, .REG_WR, .REG_RD, .LINK_UP, .REG_ADDR,
    .REG_WDATA, .REG_RDATA, .ADVERT_WORD, .AN_ENABLE, .MODE_100, .MODE_FULL, .CFG_DONE);
